/* File: core/arp_pkg.sv */
package arp_pkg;

  // Bus clock and slow timebase
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned TIMEBASE_NS     = 1000000;
  localparam int unsigned TIMEBASE_CYCLES = TIMEBASE_NS / CLK_PERIOD_NS;
  localparam int unsigned TB_CNT_W        = 14;

  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_TCS       = 6'h0D;
  localparam logic [5:0] IDX_CNT_HI    = 6'h0E;
  localparam logic [5:0] IDX_CNT_LO    = 6'h0F;
  localparam logic [5:0] IDX_RLD_HI    = 6'h10;
  localparam logic [5:0] IDX_RLD_LO    = 6'h11;
  localparam logic [5:0] IDX_OUT_CTRL  = 6'h12;
  localparam logic [5:0] IDX_PSC       = 6'h13;
  localparam logic [5:0] IDX_DUTY_HI   = 6'h17;
  localparam logic [5:0] IDX_DUTY_LO   = 6'h18;
  localparam logic [5:0] IDX_EVT_STAT  = 6'h20;
  localparam logic [5:0] IDX_EVT_MASK  = 6'h21;

  // Timer control status fields
  localparam int unsigned TCS_CKSEL_LSB = 3;
  localparam int unsigned TCS_OVF       = 2;
  localparam int unsigned TCS_OVERFLOW_IRQ_ENABLE     = 1;
  localparam int unsigned TCS_COMPARE_IRQ_ENABLE     = 0;

  // Pulse status control fields
  localparam int unsigned PSC_POL  = 1;
  localparam int unsigned PSC_CMPF = 0;

  // Output control field
  localparam int unsigned OC_OE = 0;

  // Event status and mask fields
  localparam int unsigned EVT_CMP = 0;
  localparam int unsigned EVT_OVF = 1;

  // Counter clock selection codes
  localparam logic [1:0] CKSEL_OFF  = 2'h0;
  localparam logic [1:0] CKSEL_SLOW = 2'h1;
  localparam logic [1:0] CKSEL_CPU  = 2'h2;

  // Counter limits and reset values
  localparam logic [11:0] CNT_MAX    = 12'hFFF;
  localparam logic [11:0] VAL_RESET  = 12'h000;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

endpackage

/* File: core/arp_tick_div.sv */
`timescale 1ns/100ps
module arp_tick_div #(
  parameter int unsigned CYCLES = arp_pkg::TIMEBASE_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);
  import arp_pkg::*;

  typedef struct packed {
    logic [TB_CNT_W-1:0] cnt;
    logic                tick;
  } arp_div_type;

  localparam logic [TB_CNT_W-1:0] LAST = TB_CNT_W'(CYCLES - 1);

  arp_div_type q;
  arp_div_type d;

  // One-cycle enable every CYCLES clocks
  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (q.cnt == LAST) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + TB_CNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule

/* File: core/arp_timer.sv */
// Operation
// - Output enable set: duty value sets pulse output duty cycle.
// - Output enable clear: duty value compared against running counter.
// - Polarity bit 1 inverts pulse output when set; reset clears it.
// - Compare flag bit 0 sets when counter equals a nonzero duty value, the shadow copy in pulse mode.
// - Reading pulse status clears compare flag; writing does not.
// - Output enable bit 0 releases pin when clear, drives pulse when set.
// - Reserved bits read as zero; software keeps them zero.
// - Every timer register resets to zero.
// - Registers decoded at indices 0D to 13, duty pair at 17, 18, event pair at 20, 21.
// - Overflow reloads counter, loads shadow duty, drives pulse high.
// - Overflow flag sets on FFF to reload; read of control clears it.
// - Clock select: 00 stop, 01 slow timebase, 10 bus clock.
// - Upper duty write suspends compare until lower byte written.
`timescale 1ns/100ps
module arp_timer #(
  parameter int unsigned TIMEBASE_CYCLES = arp_pkg::TIMEBASE_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        gpio_out,
  input  wire logic        gpio_oe_n,
  output logic             pin_out,
  output logic             pin_oe_n,
  output logic             compare_irq_req,
  output logic             overflow_irq_req,
  output logic             irq
);
  import arp_pkg::*;

  typedef struct packed {
    logic [1:0]  counter_clock_select;
    logic        overflow_irq_enable;
    logic        compare_irq_enable;
    logic        overflow_flag;
    logic [11:0] counter_value;
    logic [11:0] reload_value;
    logic        output_enable_bit;
    logic        output_polarity;
    logic        compare_match_flag;
    logic [11:0] duty_value;
    logic [11:0] duty_shadow;
    logic        compare_lock;
    logic        pulse_raw;
    logic [1:0]  evt_stat;
    logic [1:0]  evt_mask;
    logic [5:0]  wr_idx;
    logic        wr_pend;
    logic [7:0]  rdata;
  } arp_state_type;

  arp_state_type q;
  arp_state_type d;

  logic        slow_tick;
  logic        cnt_tick;
  logic [11:0] cmp_val;
  logic        match_evt;
  logic        ovf_evt;
  logic        addr_ok;
  logic        rd_take;
  logic        wr_take;
  logic [5:0]  rd_idx;
  logic [7:0]  rd_byte;
  logic [7:0]  wbyte;
  logic        pulse_pol;

  arp_tick_div #(
    .CYCLES (TIMEBASE_CYCLES)
  ) u_tick_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (slow_tick)
  );

  // Counter clock selection, reserved code stops the counter
  always_comb begin
    case (q.counter_clock_select)
      CKSEL_SLOW: cnt_tick = slow_tick;
      CKSEL_CPU:  cnt_tick = 1'b1;
      default:    cnt_tick = 1'b0;
    endcase
  end

  // Pulse mode compares the shadow, compare mode the live duty value
  assign cmp_val = q.output_enable_bit ? q.duty_shadow : q.duty_value;

  // Compare is idle for zero duty and while the pair is half written
  assign match_evt = cnt_tick && !q.compare_lock && (cmp_val != VAL_RESET)
                     && (q.counter_value == cmp_val);
  assign ovf_evt   = cnt_tick && (q.counter_value == CNT_MAX);

  // Address phase decode, only the low 256 bytes of the map are populated
  assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  assign rd_idx  = haddr[7:2];
  assign rd_take = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;
  assign wr_take = hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite;
  assign wbyte   = hwdata[7:0];

  // Read multiplexer, reserved bits and unmapped words read zero
  always_comb begin
    rd_byte = BYTE_RESET;
    if (addr_ok) begin
      case (rd_idx)
        IDX_TCS: begin
          rd_byte[TCS_CKSEL_LSB +: 2] = q.counter_clock_select;
          rd_byte[TCS_OVF]            = q.overflow_flag;
          rd_byte[TCS_OVERFLOW_IRQ_ENABLE]          = q.overflow_irq_enable;
          rd_byte[TCS_COMPARE_IRQ_ENABLE]          = q.compare_irq_enable;
        end
        IDX_CNT_HI:   rd_byte = {4'h0, q.counter_value[11:8]};
        IDX_CNT_LO:   rd_byte = q.counter_value[7:0];
        IDX_RLD_HI:   rd_byte = {4'h0, q.reload_value[11:8]};
        IDX_RLD_LO:   rd_byte = q.reload_value[7:0];
        IDX_OUT_CTRL: rd_byte[OC_OE] = q.output_enable_bit;
        IDX_PSC: begin
          rd_byte[PSC_POL]  = q.output_polarity;
          rd_byte[PSC_CMPF] = q.compare_match_flag;
        end
        IDX_DUTY_HI:  rd_byte = {4'h0, q.duty_value[11:8]};
        IDX_DUTY_LO:  rd_byte = q.duty_value[7:0];
        IDX_EVT_STAT: rd_byte = {6'h00, q.evt_stat};
        IDX_EVT_MASK: rd_byte = {6'h00, q.evt_mask};
        default:      rd_byte = BYTE_RESET;
      endcase
    end
  end

  always_comb begin
    d         = q;
    d.wr_pend = 1'b0;

    // Counter runs up and reloads on overflow
    if (ovf_evt) begin
      d.counter_value = q.reload_value;
      d.duty_shadow   = q.duty_value;
    end else if (cnt_tick) begin
      d.counter_value = q.counter_value + 12'h001;
    end

    // Pulse goes high at overflow and low at match in pulse mode
    if (ovf_evt) begin
      d.pulse_raw = 1'b1;
    end else if (match_evt && q.output_enable_bit) begin
      d.pulse_raw = 1'b0;
    end

    // Address phase, a read captures data and clears its flag
    if (rd_take) begin
      d.rdata = rd_byte;
      if (addr_ok && (rd_idx == IDX_TCS)) begin
        d.overflow_flag = 1'b0;
      end
      if (addr_ok && (rd_idx == IDX_PSC)) begin
        d.compare_match_flag = 1'b0;
      end
    end
    if (wr_take && addr_ok) begin
      d.wr_pend = 1'b1;
      d.wr_idx  = rd_idx;
    end

    // Data phase of a write, reserved bits are dropped
    if (q.wr_pend) begin
      case (q.wr_idx)
        IDX_TCS: begin
          d.counter_clock_select = wbyte[TCS_CKSEL_LSB +: 2];
          d.overflow_irq_enable  = wbyte[TCS_OVERFLOW_IRQ_ENABLE];
          d.compare_irq_enable   = wbyte[TCS_COMPARE_IRQ_ENABLE];
        end
        IDX_RLD_HI:   d.reload_value[11:8] = wbyte[3:0];
        IDX_RLD_LO:   d.reload_value[7:0]  = wbyte;
        IDX_OUT_CTRL: d.output_enable_bit  = wbyte[OC_OE];
        IDX_PSC:      d.output_polarity    = wbyte[PSC_POL];
        IDX_DUTY_HI: begin
          d.duty_value[11:8] = wbyte[3:0];
          d.compare_lock     = 1'b1;
        end
        IDX_DUTY_LO: begin
          d.duty_value[7:0] = wbyte;
          d.compare_lock    = 1'b0;
        end
        IDX_EVT_STAT: d.evt_stat = q.evt_stat & ~wbyte[1:0];
        IDX_EVT_MASK: d.evt_mask = wbyte[1:0];
        default:      d.evt_mask = q.evt_mask;
      endcase
    end

    // Hardware sets win over any clear in the same cycle
    if (ovf_evt) begin
      d.overflow_flag     = 1'b1;
      d.evt_stat[EVT_OVF] = 1'b1;
    end
    if (match_evt) begin
      d.compare_match_flag = 1'b1;
      d.evt_stat[EVT_CMP]  = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = {24'h000000, q.rdata};

  // Polarity sits between pulse logic and pin routing
  assign pulse_pol = q.pulse_raw ^ q.output_polarity;
  assign pin_out   = q.output_enable_bit ? pulse_pol : gpio_out;
  assign pin_oe_n  = q.output_enable_bit ? 1'b0 : gpio_oe_n;

  // Interrupt requests
  assign compare_irq_req  = q.compare_match_flag && q.compare_irq_enable;
  assign overflow_irq_req = q.overflow_flag && q.overflow_irq_enable;
  assign irq              = |(q.evt_stat & q.evt_mask);

endmodule

/* File: tb/arp_timer_chk.sv */
`timescale 1ns/100ps
module arp_timer_chk
  import arp_pkg::*;
#(
  parameter int unsigned TIMEBASE_CYCLES = 8
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        gpio_out,
  input wire logic        gpio_oe_n,
  input wire logic        pin_out,
  input wire logic        pin_oe_n,
  input wire logic        compare_irq_req,
  input wire logic        overflow_irq_req,
  input wire logic        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_tk(logic [5:0] i, logic w);
    hsel && hready && htrans == HTRANS_NONSEQ && hwrite == w && haddr == {24'h0, i, 2'h0};
  endsequence
  property p_rsv; hrdata[31:8] == 24'h0; endproperty
  property p_oe; pin_oe_n != gpio_oe_n |-> !pin_oe_n; endproperty
  property p_rel; pin_oe_n |-> pin_out == gpio_out; endproperty
  property p_rst; $rose(hresetn) |-> hrdata == 32'h0 && !irq; endproperty
  property p_cmp; s_tk(IDX_PSC, 1'b0) ##0 compare_irq_req |=> hrdata[0]; endproperty
  property p_ovf; s_tk(IDX_TCS, 1'b0) ##0 overflow_irq_req |=> hrdata[2]; endproperty
  property p_unm; s_tk(6'h14, 1'b0) |=> hrdata == 32'h0; endproperty
  property p_wrk;
    s_tk(IDX_PSC, 1'b1) ##0 compare_irq_req ##1 !hsel |=> compare_irq_req;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read bits set");
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  a_rel: assert property (p_rel) else $error("released pin level wrong");
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_cmp: assert property (p_cmp) else $error("compare flag not read");
  a_ovf: assert property (p_ovf) else $error("overflow flag not read");
  a_unm: assert property (p_unm) else $error("unmapped read nonzero");
  a_wrk: assert property (p_wrk) else $error("write cleared flag");
endmodule

bind arp_timer arp_timer_chk #(.TIMEBASE_CYCLES(TIMEBASE_CYCLES)) arp_timer_chk_i (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hreadyout, .hresp, .hrdata, .gpio_out, .gpio_oe_n, .pin_out, .pin_oe_n,
  .compare_irq_req, .overflow_irq_req, .irq
);

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import arp_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        gpio_out = 1'b0;
  logic        gpio_oe_n = 1'b1;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        pin_out;
  logic        pin_oe_n;
  logic        compare_irq_req;
  logic        overflow_irq_req;
  logic        irq;
  logic [31:0] r;
  logic [7:0]  d;
  logic [11:0] duty;
  int          fails = 0;
  int          cmp_count = 0;
  int          n;
  logic [5:0]  rw_i [4] = '{IDX_RLD_HI, IDX_RLD_LO, IDX_DUTY_HI, IDX_DUTY_LO};
  logic [7:0]  rw_m [4] = '{8'h0F, 8'hFF, 8'h0F, 8'hFF};
  logic [5:0]  all_i [9] = '{IDX_TCS, IDX_CNT_HI, IDX_CNT_LO, IDX_RLD_HI, IDX_RLD_LO,
                             IDX_OUT_CTRL, IDX_PSC, IDX_DUTY_HI, IDX_DUTY_LO};

  always #50 hclk = ~hclk;

  arp_timer #(.TIMEBASE_CYCLES(8)) arp_timer_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .gpio_out, .gpio_oe_n,
    .pin_out, .pin_oe_n, .compare_irq_req, .overflow_irq_req, .irq
  );

  // High cycles of the pin over two 16-count periods from reload FF0
  function automatic logic [31:0] pulse_high(logic [11:0] dv, logic pol);
    logic [31:0] h;
    h = 32'(2 * (dv - 12'hFF0 + 12'h1));
    return pol ? 32'd32 - h : h;
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic bus(input logic [5:0] i, input logic w, input logic [7:0] dat);
    hsel <= 1'b1;
    haddr <= {24'h0, i, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, dat};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wt(input logic o);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while ((o ? overflow_irq_req : compare_irq_req) !== 1'b1 && n < 4200);
    @(posedge hclk);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge hclk);
    fails++;
    report_and_stop;
  end

  initial begin
    r = $urandom(32'hCFB7F519);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom) & rw_m[i];
      bus(rw_i[i], 1'b1, d);
      bus(rw_i[i], 1'b0, 8'h00);
      chk("rw", r, {24'h0, d & rw_m[i]});
    end
    d = 8'($urandom);
    bus(IDX_OUT_CTRL, 1'b1, d & 8'h01);
    bus(IDX_OUT_CTRL, 1'b0, 8'h00);
    chk("oc", r, {31'h0, d[0]});
    chk("oen", pin_oe_n, !d[0]);
    bus(IDX_PSC, 1'b1, d & 8'h03);
    bus(IDX_PSC, 1'b0, 8'h00);
    chk("psc", r, {24'h0, d & 8'h02});
    bus(IDX_TCS, 1'b1, d & 8'h07);
    bus(IDX_TCS, 1'b0, 8'h00);
    chk("tcs", r, {24'h0, d & 8'h03});
    bus(IDX_CNT_LO, 1'b1, 8'hAB);
    bus(IDX_CNT_LO, 1'b0, 8'h00);
    chk("cnt", r, 32'h0);
    bus(6'h14, 1'b1, 8'hFF);
    bus(6'h14, 1'b0, 8'h00);
    chk("unm", r, 32'h0);
    chk("rsp", {hreadyout, hresp}, 32'h2);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (all_i[i]) begin
      bus(all_i[i], 1'b0, 8'h00);
      chk("rst", r, 32'h0);
    end
    gpio_out <= 1'($urandom);
    gpio_oe_n <= 1'b0;
    @(negedge hclk);
    chk("gpo", pin_out, gpio_out);
    chk("gpe", pin_oe_n, 1'b0);
    @(posedge hclk);
    bus(IDX_DUTY_HI, 1'b1, 8'h00);
    bus(IDX_DUTY_LO, 1'b1, 8'h05);
    bus(IDX_DUTY_HI, 1'b1, 8'h00);
    bus(IDX_TCS, 1'b1, {3'h0, CKSEL_CPU, 3'h1});
    wt(1'b0);
    chk("lock", compare_irq_req, 1'b0);
    bus(IDX_DUTY_LO, 1'b1, 8'h05);
    wt(1'b0);
    chk("cmp", compare_irq_req, 1'b1);
    bus(IDX_PSC, 1'b1, 8'h00);
    bus(IDX_PSC, 1'b0, 8'h00);
    chk("keep", r, 32'h1);
    bus(IDX_PSC, 1'b0, 8'h00);
    chk("clr", r, 32'h0);
    chk("cirq", compare_irq_req, 1'b0);
    chk("msk", irq, 1'b0);
    bus(IDX_EVT_MASK, 1'b1, 8'h01);
    @(negedge hclk);
    chk("irq", irq, 1'b1);
    @(posedge hclk);
    bus(IDX_EVT_STAT, 1'b1, 8'h01);
    @(negedge hclk);
    chk("w1c", irq, 1'b0);
    @(posedge hclk);
    bus(IDX_RLD_HI, 1'b1, 8'h0F);
    bus(IDX_RLD_LO, 1'b1, 8'hF0);
    // Drop an overflow flag left from the long compare waits
    bus(IDX_TCS, 1'b0, 8'h00);
    bus(IDX_TCS, 1'b1, {3'h0, CKSEL_CPU, 3'h2});
    wt(1'b1);
    bus(IDX_TCS, 1'b0, 8'h00);
    chk("ovf", r, 32'h16);
    chk("oclr", overflow_irq_req, 1'b0);
    duty = 12'hFF1 + 12'($urandom % 14);
    bus(IDX_DUTY_HI, 1'b1, {4'h0, duty[11:8]});
    bus(IDX_DUTY_LO, 1'b1, duty[7:0]);
    bus(IDX_OUT_CTRL, 1'b1, 8'h01);
    for (int p = 0; p < 2; p++) begin
      bus(IDX_PSC, 1'b1, {6'h0, p[0], 1'b0});
      repeat (40) @(posedge hclk);
      n = 0;
      repeat (32) begin
        @(negedge hclk);
        n += int'(pin_out);
      end
      chk("pwm", n, pulse_high(duty, p[0]));
      chk("pin", pin_oe_n, 1'b0);
      @(posedge hclk);
    end
    // Stopped counter holds, slow timebase steps once per eight clocks
    bus(IDX_TCS, 1'b1, 8'h00);
    bus(IDX_CNT_LO, 1'b0, 8'h00);
    d = r[7:0];
    repeat (20) @(posedge hclk);
    bus(IDX_CNT_LO, 1'b0, 8'h00);
    chk("off", r, {24'h0, d});
    bus(IDX_TCS, 1'b1, {3'h0, CKSEL_SLOW, 3'h0});
    bus(IDX_CNT_LO, 1'b0, 8'h00);
    d = r[7:0];
    repeat (62) @(posedge hclk);
    bus(IDX_CNT_LO, 1'b0, 8'h00);
    chk("slow", r, {24'h0, 4'hF, d[3:0] + 4'h8});
    report_and_stop;
  end
endmodule
